// ===== dspc_pkg.sv
// constants for the dsp output and self-test configuration bank
package dspc_pkg;

  // ----------------------------------------------------------------
  // register indices and apb byte addresses
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 12;
  localparam logic [7:0]  IDX_SLOT_CFG = 8'h42;
  localparam logic [7:0]  IDX_PIN_CFG  = 8'h43;
  localparam logic [7:0]  IDX_ST_CFG   = 8'h44;
  localparam logic [11:0] ADDR_SLOT    = {2'b00, IDX_SLOT_CFG, 2'b00};
  localparam logic [11:0] ADDR_PIN     = {2'b00, IDX_PIN_CFG, 2'b00};
  localparam logic [11:0] ADDR_ST      = {2'b00, IDX_ST_CFG, 2'b00};
  localparam logic [11:0] ADDR_RES0    = 12'h200;
  localparam logic [11:0] ADDR_RES1    = 12'h204;
  localparam logic [11:0] ADDR_STAT    = 12'h208;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  SLOT_CFG_RST = 8'h00;
  localparam logic [7:0]  PIN_CFG_RST  = 8'h00;
  localparam logic [7:0]  ST_CFG_RST   = 8'h00;
  localparam int          PIN_MODE_BIT = 2;
  localparam int          ST_SEL_MSB   = 7;
  localparam int          ST_SEL_LSB   = 4;
  localparam int          ST_RSV_MSB   = 3;
  localparam int          SLOT1_MSB    = 3;
  localparam int          SLOT1_LSB    = 2;
  localparam int          STAT_ERR_BIT = 0;
  localparam int          STAT_PIN_BIT = 1;

  // ----------------------------------------------------------------
  // select codes and fixed patterns
  // ----------------------------------------------------------------
  localparam logic [3:0]  ST_NORMAL    = 4'h0;
  localparam logic [3:0]  ST_CM_VERIFY = 4'h1;
  localparam logic [1:0]  ST_GRP_PAT   = 2'b01;
  localparam logic [1:0]  ST_GRP_DST   = 2'b11;
  localparam logic [1:0]  SRC_PABS     = 2'b01;
  localparam logic [1:0]  SRC_TEMP     = 2'b11;
  localparam logic [15:0] PAT_0        = 16'h0000;
  localparam logic [15:0] PAT_1        = 16'hAAAA;
  localparam logic [15:0] PAT_2        = 16'h5555;
  localparam logic [15:0] PAT_3        = 16'hFFFF;

endpackage

// ===== dspc_array_check.sv
// parity guard over the configuration bits covered by array error detection
`timescale 1ns/100ps
`default_nettype none
module dspc_array_check #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] nextBits,
  input  wire logic [WIDTH-1:0] curBits,
  output logic                  mismatch
);
  typedef struct packed {
    logic parity;
  } dspc_chk_t;

  dspc_chk_t st;
  dspc_chk_t next_st;

  // parity is captured with the very word written, so a legal write never trips it
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.parity = ^nextBits;
    end
    mismatch = (^curBits) != st.parity;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// ===== dspc_result_mux.sv
// chooses what each result slot receives for the current test-function select
`timescale 1ns/100ps
`default_nettype none
module dspc_result_mux import dspc_pkg::*; #(
  parameter int RES_W = 16
) (
  input  wire logic [3:0]       testSel,
  input  wire logic [1:0]       slot1Src,
  input  wire logic [RES_W-1:0] pressureIn,
  input  wire logic [RES_W-1:0] tempIn,
  input  wire logic [RES_W-1:0] selfTestData,
  output logic [2*RES_W-1:0]    slotVal,
  output logic                  inhibit,
  output logic                  loadOk
);
  logic [RES_W-1:0] pattern;

  always_comb begin
    case (testSel[1:0])
      2'd0:    pattern = RES_W'(PAT_0);
      2'd1:    pattern = RES_W'(PAT_1);
      2'd2:    pattern = RES_W'(PAT_2);
      default: pattern = RES_W'(PAT_3);
    endcase
    inhibit = testSel[3:2] == ST_GRP_PAT;
    // reserved codes leave the slots untouched
    loadOk  = testSel == ST_NORMAL || testSel == ST_CM_VERIFY
              || testSel[3:2] == ST_GRP_DST;
  end

  for (genvar i = 0; i < 2; i++) begin : g_slot
    logic [RES_W-1:0] src;
    always_comb begin
      if (i == 1 && slot1Src == SRC_TEMP) begin
        src = tempIn;
      end else begin
        src = pressureIn;
      end
      if (testSel[3:2] == ST_GRP_PAT) begin
        slotVal[i*RES_W +: RES_W] = pattern;
      end else if (testSel[3:2] == ST_GRP_DST) begin
        slotVal[i*RES_W +: RES_W] = selfTestData;
      end else begin
        slotVal[i*RES_W +: RES_W] = src;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dspc_config_bank.sv
// apb register bank for interrupt pin drive mode and self-test result selection
//
// Behaviour
// - An 8-bit read/write pin configuration register sits at index 43h, bit 2 is the drive mode, all bits reset to 0.
// - Drive mode 0 gives an active-high interrupt with pull-down, mode 1 an active-low one with pull-up.
// - The pin and self-test registers are guarded by the array error check, except the test select field; the slot register is not.
// - An 8-bit read/write self-test register sits at index 44h, bits 7:4 select the test, all bits reset to 0.
// - Writes to the test select field never raise an array error.
// - Select 0000 loads normal 16-bit pressure results.
// - Select 0001 runs the common-mode check while still loading 16-bit pressure results.
// - Selects 0100 to 0111 block processor writes and show 0000h, AAAAh, 5555h and FFFFh.
// - Selects 1100 to 1111 run digital self-test 0 to 3 and load its output instead of sensor data.
// - The slot 1 source select picks pressure for 01 and temperature for 11.
`timescale 1ns/100ps
`default_nettype none
module dspc_config_bank import dspc_pkg::*; #(
  parameter int RES_W = 16
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              dspValid,
  input  wire logic [RES_W-1:0]  pressureIn,
  input  wire logic [RES_W-1:0]  tempIn,
  input  wire logic [RES_W-1:0]  selfTestData,
  input  wire logic              intReq,
  input  wire logic              intPinIn,
  output logic                   intPinOut,
  output logic                   intPinOe,
  output logic                   pullUpEn,
  output logic                   pullDownEn,
  output logic                   cmVerifyEn,
  output logic                   selfTestEn,
  output logic [1:0]             selfTestIdx,
  output logic [RES_W-1:0]       resultSlot0,
  output logic [RES_W-1:0]       resultSlot1,
  output logic                   arrayErr
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ACCESS = 2'b10
  } dspc_bus_t;

  typedef struct packed {
    dspc_bus_t        bus;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic [7:0]       slotCfg;
    logic [7:0]       pinCfg;
    logic [7:0]       stCfg;
    logic             arrayErr;
    logic             pinLevel;
    logic             intPinOut;
    logic             intPinOe;
    logic             pullUpEn;
    logic             pullDownEn;
    logic             cmVerifyEn;
    logic             selfTestEn;
    logic [1:0]       selfTestIdx;
    logic [RES_W-1:0] res0;
    logic [RES_W-1:0] res1;
  } dspc_state_t;

  localparam dspc_state_t STATE_RST = '{
    bus:        BUS_IDLE,
    pready:     1'b0,
    pslverr:    1'b0,
    prdata:     32'h0000_0000,
    slotCfg:    SLOT_CFG_RST,
    pinCfg:     PIN_CFG_RST,
    stCfg:      ST_CFG_RST,
    arrayErr:   1'b0,
    pinLevel:   1'b0,
    intPinOut:  1'b1,
    intPinOe:   1'b0,
    pullUpEn:   1'b0,
    pullDownEn: 1'b1,
    cmVerifyEn: 1'b0,
    selfTestEn: 1'b0,
    selfTestIdx: 2'b00,
    res0:       '0,
    res1:       '0
  };

  dspc_state_t          st;
  dspc_state_t          next_st;
  logic                 setup;
  logic                 wrEn;
  logic                 mapped;
  logic [31:0]          readVal;
  logic [3:0]           testSel;
  logic [2*RES_W-1:0]   slotVal;
  logic                 inhibit;
  logic                 loadOk;
  logic                 chkLoad;
  logic                 chkErr;
  logic [11:0]          chkNext;
  logic [11:0]          chkCur;

  assign testSel = st.stCfg[ST_SEL_MSB:ST_SEL_LSB];
  // test select bits are left out of the guarded vector
  assign chkCur  = {st.pinCfg, st.stCfg[ST_RSV_MSB:0]};
  assign chkNext = {next_st.pinCfg, next_st.stCfg[ST_RSV_MSB:0]};

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  dspc_result_mux #(
    .RES_W        (RES_W)
  ) u_mux (
    .testSel      (testSel),
    .slot1Src     (st.slotCfg[SLOT1_MSB:SLOT1_LSB]),
    .pressureIn   (pressureIn),
    .tempIn       (tempIn),
    .selfTestData (selfTestData),
    .slotVal      (slotVal),
    .inhibit      (inhibit),
    .loadOk       (loadOk)
  );

  dspc_array_check #(
    .WIDTH    (12)
  ) u_chk (
    .clk      (clk),
    .rst      (rst),
    .load     (chkLoad),
    .nextBits (chkNext),
    .curBits  (chkCur),
    .mismatch (chkErr)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    setup   = psel & ~penable;
    wrEn    = psel & penable & pwrite & st.pready & (st.bus == BUS_ACCESS);
    mapped  = 1'b1;
    readVal = 32'h0000_0000;
    case (paddr)
      ADDR_SLOT: readVal = {24'h000000, st.slotCfg};
      ADDR_PIN:  readVal = {24'h000000, st.pinCfg};
      ADDR_ST:   readVal = {24'h000000, st.stCfg};
      ADDR_RES0: readVal = {{(32-RES_W){1'b0}}, st.res0};
      ADDR_RES1: readVal = {{(32-RES_W){1'b0}}, st.res1};
      ADDR_STAT: readVal = {30'h0000_0000, st.pinLevel, st.arrayErr};
      default:   mapped  = 1'b0;
    endcase
    // one wait-free access phase: answer is prepared during setup
    next_st.bus     = setup ? BUS_ACCESS : BUS_IDLE;
    next_st.pready  = setup;
    next_st.pslverr = setup & ~mapped;
    next_st.prdata  = (setup & ~pwrite & mapped) ? readVal : 32'h0000_0000;
    chkLoad = 1'b0;
    if (wrEn & pstrb[0]) begin
      case (paddr)
        ADDR_SLOT: next_st.slotCfg = pwdata[7:0];
        ADDR_PIN: begin
          next_st.pinCfg = pwdata[7:0];
          chkLoad        = 1'b1;
        end
        ADDR_ST: begin
          next_st.stCfg = pwdata[7:0];
          chkLoad       = 1'b1;
        end
        default: chkLoad = 1'b0;
      endcase
    end
    // new error wins over a write-one clear in the same cycle
    if (chkErr) begin
      next_st.arrayErr = 1'b1;
    end else if (wrEn & pstrb[0] & (paddr == ADDR_STAT) & pwdata[STAT_ERR_BIT]) begin
      next_st.arrayErr = 1'b0;
    end
    next_st.pinLevel   = intPinIn;
    // open drain: only the active level is driven, the pull holds the idle level
    next_st.intPinOe   = intReq;
    next_st.intPinOut  = ~st.pinCfg[PIN_MODE_BIT];
    next_st.pullUpEn   = st.pinCfg[PIN_MODE_BIT];
    next_st.pullDownEn = ~st.pinCfg[PIN_MODE_BIT];
    next_st.cmVerifyEn = testSel == ST_CM_VERIFY;
    next_st.selfTestEn = testSel[3:2] == ST_GRP_DST;
    next_st.selfTestIdx = testSel[1:0];
    if (inhibit || (dspValid && loadOk)) begin
      next_st.res0 = slotVal[RES_W-1:0];
      next_st.res1 = slotVal[2*RES_W-1:RES_W];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata      = st.prdata;
  assign pready      = st.pready;
  assign pslverr     = st.pslverr;
  assign intPinOut   = st.intPinOut;
  assign intPinOe    = st.intPinOe;
  assign pullUpEn    = st.pullUpEn;
  assign pullDownEn  = st.pullDownEn;
  assign cmVerifyEn  = st.cmVerifyEn;
  assign selfTestEn  = st.selfTestEn;
  assign selfTestIdx = st.selfTestIdx;
  assign resultSlot0 = st.res0;
  assign resultSlot1 = st.res1;
  assign arrayErr    = st.arrayErr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  pin_cfg_write_a: assert property (
    @(posedge clk) disable iff (rst)
    (wrEn && pstrb[0] && paddr == ADDR_PIN)
      |=> (st.pinCfg == $past(pwdata[7:0])) ##1 (pullUpEn == st.pinCfg[PIN_MODE_BIT]))
    else $error("pin config write not stored");

  pin_cfg_read_a: assert property (
    @(posedge clk) disable iff (rst)
    (psel && !penable && !pwrite && paddr == ADDR_PIN)
      |=> pready && prdata == {24'h000000, $past(st.pinCfg)})
    else $error("pin config read wrong");

  pin_drive_mode_a: assert property (
    @(posedge clk) disable iff (rst)
    ##1 (intPinOut == ~$past(st.pinCfg[PIN_MODE_BIT])) && (pullUpEn != pullDownEn)
      && (intPinOe == $past(intReq)))
    else $error("interrupt pin drive does not follow mode bit");

  array_err_set_a: assert property (
    @(posedge clk) disable iff (rst)
    chkErr |=> arrayErr [*2])
    else $error("array error flag not held after mismatch");

  st_cfg_write_a: assert property (
    @(posedge clk) disable iff (rst)
    (wrEn && pstrb[0] && paddr == ADDR_ST) |=> st.stCfg == $past(pwdata[7:0]))
    else $error("self-test config write not stored");

  st_sel_no_err_a: assert property (
    @(posedge clk) disable iff (rst)
    (wrEn && pstrb[0] && paddr == ADDR_ST && !chkErr
      && pwdata[ST_RSV_MSB:0] == st.stCfg[ST_RSV_MSB:0]) |=> !chkErr)
    else $error("select field change raised array error");

  normal_load_a: assert property (
    @(posedge clk) disable iff (rst)
    (testSel == ST_NORMAL && dspValid) |=> resultSlot0 == $past(pressureIn))
    else $error("pressure not loaded in normal mode");

  cm_verify_a: assert property (
    @(posedge clk) disable iff (rst)
    (testSel == ST_CM_VERIFY && dspValid)
      |=> cmVerifyEn && resultSlot0 == $past(pressureIn))
    else $error("common-mode check mode wrong");

  cm_verify_off_a: assert property (
    @(posedge clk) disable iff (rst)
    (testSel != ST_CM_VERIFY) |=> !cmVerifyEn)
    else $error("common-mode check enabled outside its select");

  pattern_fill_a: assert property (
    @(posedge clk) disable iff (rst)
    (testSel == 4'h5 && $stable(testSel)) |=> resultSlot0 == 16'hAAAA && resultSlot1 == 16'hAAAA)
    else $error("test pattern not shown");

  pattern_ones_a: assert property (
    @(posedge clk) disable iff (rst)
    (testSel == 4'h7 && $stable(testSel))
      |=> resultSlot0 == 16'hFFFF && resultSlot1 == 16'hFFFF)
    else $error("all-ones pattern not shown");

  self_test_load_a: assert property (
    @(posedge clk) disable iff (rst)
    (testSel[3:2] == ST_GRP_DST && dspValid)
      |=> selfTestEn && resultSlot0 == $past(selfTestData)
          && selfTestIdx == $past(testSel[1:0]))
    else $error("self-test output not loaded");

  self_test_off_a: assert property (
    @(posedge clk) disable iff (rst)
    (testSel[3:2] != ST_GRP_DST) |=> !selfTestEn)
    else $error("self-test enabled outside self-test selects");

  slot1_temp_a: assert property (
    @(posedge clk) disable iff (rst)
    (testSel == ST_NORMAL && dspValid && st.slotCfg[SLOT1_MSB:SLOT1_LSB] == SRC_TEMP)
      |=> resultSlot1 == $past(tempIn))
    else $error("slot 1 temperature not loaded");
endmodule
`default_nettype wire

// ===== tb_dsp_output_and_self_test_config.sv
// self-checking testbench for the dsp output and self-test configuration bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin errorCnt++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb_dsp_output_and_self_test_config import dspc_pkg::*;;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [3:0]        pstrb = 4'h0;
  logic [31:0]       prdata;
  logic              pready, pslverr;
  logic              dspValid = 1'b0, intReq = 1'b0;
  logic [15:0]       pressureIn = '0, tempIn = '0, selfTestData = '0;
  logic              intPinIn, intPinOut, intPinOe, pullUpEn, pullDownEn;
  logic              cmVerifyEn, selfTestEn, arrayErr;
  logic [1:0]        selfTestIdx;
  logic [15:0]       resultSlot0, resultSlot1;
  logic [31:0]       rdv;
  logic              erv;
  int                errorCnt = 0;
  int                cmpCount = 0;
  logic [15:0]       pat [4] = '{PAT_0, PAT_1, PAT_2, PAT_3};

  always #10 clk = ~clk;
  // wire level: driven when enabled, otherwise the selected pull
  assign intPinIn = intPinOe ? intPinOut : pullUpEn;

  dspc_config_bank dspc_config_bank_i (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dspValid(dspValid),
    .pressureIn(pressureIn), .tempIn(tempIn), .selfTestData(selfTestData),
    .intReq(intReq), .intPinIn(intPinIn), .intPinOut(intPinOut),
    .intPinOe(intPinOe), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn),
    .cmVerifyEn(cmVerifyEn), .selfTestEn(selfTestEn), .selfTestIdx(selfTestIdx),
    .resultSlot0(resultSlot0), .resultSlot1(resultSlot1), .arrayErr(arrayErr)
  );

  // ----------------------------------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // answer taken at the edge where pready is sampled high; only the watchdog ends a hang
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 4'hF);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic pulse(input logic [15:0] p, input logic [15:0] t, input logic [15:0] s);
    @(posedge clk);
    dspValid <= 1'b1; pressureIn <= p; tempIn <= t; selfTestData <= s;
    @(posedge clk);
    dspValid <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, ADDR_PIN, '0, 4'h0);
    `CHK("pin cfg reset", 32'h0, rdv)
    apb(1'b0, ADDR_ST, '0, 4'h0);
    `CHK("st cfg reset", 32'h0, rdv)
    `CHK("pull down at reset", 1'b1, pullDownEn)
    `CHK("pull up at reset", 1'b0, pullUpEn)
    `CHK("results at reset", 16'h0, resultSlot0)
  endtask

  task automatic t_regs();
    wr(ADDR_PIN, 8'hFF);
    apb(1'b0, ADDR_PIN, '0, 4'h0);
    `CHK("pin cfg all bits", 32'hFF, rdv)
    // strobe off: write must be dropped without an error
    apb(1'b1, ADDR_PIN, 32'h00, 4'h0);
    `CHK("strobeless write err", 1'b0, erv)
    apb(1'b0, ADDR_PIN, '0, 4'h0);
    `CHK("strobeless write kept", 32'hFF, rdv)
    wr(ADDR_ST, 8'hC5);
    apb(1'b0, ADDR_ST, '0, 4'h0);
    `CHK("st cfg readback", 32'hC5, rdv)
    wr(ADDR_ST, 8'h00);
    apb(1'b0, 12'h300, '0, 4'h0);
    `CHK("unmapped read err", 1'b1, erv)
    `CHK("unmapped read data", 32'h0, rdv)
    apb(1'b1, 12'h300, 32'hFF, 4'hF);
    `CHK("unmapped write err", 1'b1, erv)
  endtask

  task automatic t_pin();
    wr(ADDR_PIN, 8'h00);
    intReq <= 1'b1;
    settle(2);
    `CHK("mode0 active oe", 1'b1, intPinOe)
    `CHK("mode0 active level", 1'b1, intPinOut)
    intReq <= 1'b0;
    settle(2);
    `CHK("mode0 idle pull down", 1'b1, pullDownEn)
    apb(1'b0, ADDR_STAT, '0, 4'h0);
    `CHK("mode0 idle wire", 1'b0, rdv[STAT_PIN_BIT])
    wr(ADDR_PIN, 8'h04);
    settle(2);
    `CHK("mode1 pull up", 1'b1, pullUpEn)
    `CHK("mode1 no pull down", 1'b0, pullDownEn)
    apb(1'b0, ADDR_STAT, '0, 4'h0);
    `CHK("mode1 idle wire", 1'b1, rdv[STAT_PIN_BIT])
    intReq <= 1'b1;
    settle(2);
    `CHK("mode1 active level", 1'b0, intPinOut)
    apb(1'b0, ADDR_STAT, '0, 4'h0);
    `CHK("mode1 active wire", 1'b0, rdv[STAT_PIN_BIT])
    intReq <= 1'b0;
  endtask

  task automatic t_norm();
    for (int sel = 0; sel < 2; sel++) begin
      wr(ADDR_ST, 8'(sel << 4));
      wr(ADDR_SLOT, 8'h04);
      pulse(16'h1234 + 16'(sel), 16'h0BEE, 16'h0);
      `CHK("normal slot0", 16'h1234 + 16'(sel), resultSlot0)
      `CHK("slot1 pressure", 16'h1234 + 16'(sel), resultSlot1)
      `CHK("cm verify enable", (sel == 1), cmVerifyEn)
      wr(ADDR_SLOT, 8'h0C);
      pulse(16'h5A01, 16'h0C3D, 16'h0);
      `CHK("slot1 temperature", 16'h0C3D, resultSlot1)
      apb(1'b0, ADDR_RES0, '0, 4'h0);
      `CHK("result0 via bus", 32'h5A01, rdv)
    end
  endtask

  task automatic t_pat();
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_ST, 8'((4 + k) << 4));
      settle(2);
      `CHK("pattern slot0", pat[k], resultSlot0)
      `CHK("pattern slot1", pat[k], resultSlot1)
      pulse(16'h3C3C, 16'h4B4B, 16'h0);
      `CHK("inhibited write", pat[k], resultSlot0)
      apb(1'b0, ADDR_RES1, '0, 4'h0);
      `CHK("pattern via bus", {16'h0, pat[k]}, rdv)
    end
  endtask

  task automatic t_dst();
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_ST, 8'((12 + k) << 4));
      pulse(16'h1111, 16'h2222, 16'h7E00 + 16'(k));
      `CHK("self-test enable", 1'b1, selfTestEn)
      `CHK("self-test index", 2'(k), selfTestIdx)
      `CHK("self-test output", 16'h7E00 + 16'(k), resultSlot0)
      `CHK("self-test slot1", 16'h7E00 + 16'(k), resultSlot1)
    end
    // only defined select codes are ever written here
    wr(ADDR_ST, 8'h00);
    settle(2);
    `CHK("self-test off", 1'b0, selfTestEn)
  endtask

  task automatic t_err();
    apb(1'b0, ADDR_STAT, '0, 4'h0);
    `CHK("status array err", 1'b0, rdv[STAT_ERR_BIT])
    `CHK("array err flag", 1'b0, arrayErr)
  endtask

  // mid-run reset must bring non-zero configuration back to defaults
  task automatic t_rerst();
    wr(ADDR_PIN, 8'hFF);
    wr(ADDR_ST, 8'h7F);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_PIN, '0, 4'h0);
    `CHK("pin cfg rerun reset", 32'h0, rdv)
    apb(1'b0, ADDR_ST, '0, 4'h0);
    `CHK("st cfg rerun reset", 32'h0, rdv)
    `CHK("pull down after rerun reset", 1'b1, pullDownEn)
    `CHK("pattern cleared by reset", 16'h0, resultSlot1)
  endtask

  // ----------------------------------------------------------------
  // sequence and verdict
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_pin();
    t_norm();
    t_pat();
    t_dst();
    t_err();
    t_rerst();
    give_verdict();
  end

  // run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    $display("[FAIL] watchdog expected done seen hang");
    give_verdict();
  end
endmodule
`default_nettype wire
